// ==== design/irf_request_flags.sv ====
// interrupt request flag registers with edge detection and enable gating
//
// Functional notes
// - timer A, serial one and five external inputs set request_flags_one bits
// - accepting an interrupt leaves flags alone; only a software 0 write clears
// - writing 0 clears a flag bit; writing 1 leaves it unchanged
// - timer A flag sets when its counter wraps from ff to 00
// - serial channel one flag sets when a transfer finishes
// - bit 5 of request_flags_one is reserved, reads 1, ignores writes
// - external flag sets only in interrupt pin mode on the selected edge
// - direct transfer flag sets on transfer after sleep with direct_transfer_on set
// - conversion flag sets when conversion completes and start flag returns low
// - serial channel two flag sets on transfer complete or abort
// - timer G flag sets on selected capture edge in capture pin mode
// - timer FH flag sets on upper match, or full 16-bit match in 16-bit mode
// - timer FL flag sets on lower compare match in 8-bit mode only
// - timer C flag sets when its counter wraps from ff to 00
// - timer B flag sets when its counter wraps from ff to 00
// - wakeup flags set on falling edge when pin is in wakeup mode
// - thirteen external sources: eight wakeup pins and five request pins
// - set flag requests interrupt only while enabled; enables reset to 0
// - edge select 0 picks falling, 1 picks rising; resets to 0
// - switching pin function may set a flag; software clears it afterwards
`timescale 1ns/100ps
module irf_request_flags #(
    parameter int NUM_EXT = 5,
    parameter int NUM_WAKE = 8
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire irf_pkg::irf_bus_t bus_in,
    output logic [7:0] rdata_out,
    input wire irf_pkg::irf_events_t events_in,
    input wire logic [NUM_EXT-1:0] external_request_pins_in,
    input wire logic [NUM_WAKE-1:0] wakeup_pins_in,
    input wire logic [NUM_WAKE-1:0] wakeup_mode_in,
    input wire logic timer_g_capture_pin_in,
    input wire logic timer_g_rising_in,
    output logic [7:0] request_flags_one_out,
    output logic [7:0] request_flags_two_out,
    output logic [7:0] wakeup_request_flags_out,
    output logic [7:0] pending_one_out,
    output logic [7:0] pending_two_out,
    output logic any_request_out
);
    logic [7:0] request_flags_one;
    logic [7:0] request_flags_two;
    logic [7:0] wakeup_request_flags;
    logic [7:0] enable_flags_one;
    logic [7:0] enable_flags_two;
    logic [7:0] edge_select_register;
    logic [7:0] pin_mode;
    logic [NUM_EXT-1:0] ext_prev;
    logic [NUM_WAKE-1:0] wake_prev;
    logic timer_g_capture_pin_prev;
    logic [7:0] rdata;

    // register decode
    wire wr_one = bus_in.wr && (bus_in.addr == irf_pkg::OFF_FLAGS_ONE);
    wire wr_two = bus_in.wr && (bus_in.addr == irf_pkg::OFF_FLAGS_TWO);
    wire wr_wake = bus_in.wr && (bus_in.addr == irf_pkg::OFF_WAKE_FLAGS);
    wire wr_en_one = bus_in.wr && (bus_in.addr == irf_pkg::OFF_ENABLE_ONE);
    wire wr_en_two = bus_in.wr && (bus_in.addr == irf_pkg::OFF_ENABLE_TWO);
    wire wr_edge = bus_in.wr && (bus_in.addr == irf_pkg::OFF_EDGE_SEL);
    wire wr_mode = bus_in.wr && (bus_in.addr == irf_pkg::OFF_PIN_MODE);

    // clear masks: a 0 written clears, a 1 keeps
    wire [7:0] clr_one = wr_one ? ~bus_in.wdata : 8'h00;
    wire [7:0] clr_two = wr_two ? ~bus_in.wdata : 8'h00;
    wire [7:0] clr_wake = wr_wake ? ~bus_in.wdata : 8'h00;

    // external pin edge detection, per pin
    wire [NUM_EXT-1:0] ext_set;
    wire [NUM_WAKE-1:0] wake_set;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EXT; gi++) begin : g_ext
            wire rise = external_request_pins_in[gi] && !ext_prev[gi];
            wire fall = !external_request_pins_in[gi] && ext_prev[gi];
            wire hit = edge_select_register[gi] ? rise : fall;
            assign ext_set[gi] = pin_mode[gi] && hit;
        end
        for (gi = 0; gi < NUM_WAKE; gi++) begin : g_wake
            wire fall = !wakeup_pins_in[gi] && wake_prev[gi];
            assign wake_set[gi] = wakeup_mode_in[gi] && fall;
        end
    endgenerate

    // timer G capture edge, polarity chosen by the timer, mode by pin_mode bit MODE_TIMER_G
    wire timer_g_capture_pin_rise = timer_g_capture_pin_in && !timer_g_capture_pin_prev;
    wire timer_g_capture_pin_fall = !timer_g_capture_pin_in && timer_g_capture_pin_prev;
    wire timer_g_capture_pin_hit = timer_g_rising_in ? timer_g_capture_pin_rise : timer_g_capture_pin_fall;
    wire tg_set = pin_mode[irf_pkg::MODE_TIMER_G] && (timer_g_capture_pin_hit || events_in.timer_g_edge);

    // conversion done counts only with the start flag back at reset
    wire conv_set = events_in.conversion_done && !events_in.conversion_start_flag;

    wire fh_set = events_in.timer_f_high_match;
    wire fl_set = events_in.timer_f_low_match && !events_in.timer_f_16bit_mode;
    wire dt_set = events_in.direct_transfer && events_in.direct_transfer_on;

    logic [7:0] set_one;
    logic [7:0] set_two;
    always_comb begin
        set_one = 8'h00;
        set_one[irf_pkg::ONE_TIMER_A] = events_in.timer_a_wrap;
        set_one[irf_pkg::ONE_SERIAL_ONE] = events_in.serial_one_done;
        set_one[NUM_EXT-1:0] = ext_set;
        set_two = 8'h00;
        set_two[irf_pkg::TWO_DIRECT] = dt_set;
        set_two[irf_pkg::TWO_CONVERSION] = conv_set;
        set_two[irf_pkg::TWO_SERIAL_TWO] = events_in.serial_two_end;
        set_two[irf_pkg::TWO_TIMER_G] = tg_set;
        set_two[irf_pkg::TWO_TIMER_FH] = fh_set;
        set_two[irf_pkg::TWO_TIMER_FL] = fl_set;
        set_two[irf_pkg::TWO_TIMER_C] = events_in.timer_c_wrap;
        set_two[irf_pkg::TWO_TIMER_B] = events_in.timer_b_wrap;
    end

    // set wins over clear; reserved bit forced to 1
    wire [7:0] next_one = ((request_flags_one & ~clr_one) | set_one)
        | irf_pkg::RESERVED_MASK;
    wire [7:0] next_two = (request_flags_two & ~clr_two) | set_two;
    wire [7:0] next_wake = (wakeup_request_flags & ~clr_wake)
        | 8'(wake_set);

    // pending requests, wakeup flags share one enable
    wire [7:0] pend_one = request_flags_one & enable_flags_one
        & ~irf_pkg::RESERVED_MASK;
    wire wake_pend = (|wakeup_request_flags) && enable_flags_one[irf_pkg::EN_ONE_WAKE];
    wire [7:0] pend_two = request_flags_two & enable_flags_two;

    always_comb begin
        unique case (bus_in.addr)
            irf_pkg::OFF_FLAGS_ONE: rdata = request_flags_one;
            irf_pkg::OFF_FLAGS_TWO: rdata = request_flags_two;
            irf_pkg::OFF_WAKE_FLAGS: rdata = wakeup_request_flags;
            irf_pkg::OFF_ENABLE_ONE: rdata = enable_flags_one;
            irf_pkg::OFF_ENABLE_TWO: rdata = enable_flags_two;
            irf_pkg::OFF_EDGE_SEL: rdata = edge_select_register;
            irf_pkg::OFF_PIN_MODE: rdata = pin_mode;
            irf_pkg::OFF_REQ_STATUS: rdata = {7'h00, any_request_out};
            default: rdata = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            request_flags_one <= irf_pkg::RST_FLAGS_ONE;
            request_flags_two <= irf_pkg::RST_ZERO;
            wakeup_request_flags <= irf_pkg::RST_ZERO;
            rdata_out <= irf_pkg::RST_ZERO;
        end else begin
            request_flags_one <= next_one;
            request_flags_two <= next_two;
            wakeup_request_flags <= next_wake;
            rdata_out <= bus_in.rd ? rdata : 8'h00;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            enable_flags_one <= irf_pkg::RST_ZERO;
            enable_flags_two <= irf_pkg::RST_ZERO;
            edge_select_register <= irf_pkg::RST_ZERO;
            pin_mode <= irf_pkg::RST_ZERO;
        end else begin
            if (wr_en_one) enable_flags_one <= bus_in.wdata;
            if (wr_en_two) enable_flags_two <= bus_in.wdata;
            if (wr_edge) edge_select_register <= bus_in.wdata;
            if (wr_mode) pin_mode <= bus_in.wdata;
        end
    end

    // previous pin levels; pin mode changes can produce a spurious edge, software clears it
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            ext_prev <= '1;
            wake_prev <= '1;
            timer_g_capture_pin_prev <= 1'b1;
        end else begin
            ext_prev <= external_request_pins_in;
            wake_prev <= wakeup_pins_in;
            timer_g_capture_pin_prev <= timer_g_capture_pin_in;
        end
    end

    assign request_flags_one_out = request_flags_one;
    assign request_flags_two_out = request_flags_two;
    assign wakeup_request_flags_out = wakeup_request_flags;
    assign pending_one_out = pend_one | (wake_pend ? irf_pkg::RESERVED_MASK : 8'h00);
    assign pending_two_out = pend_two;
    assign any_request_out = (|pend_one) || wake_pend || (|pend_two);

    // assertions
    reserved_one_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        ##1 request_flags_one[irf_pkg::ONE_RESERVED])
        else $error("reserved bit not 1");
    write_one_keeps_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_two && bus_in.wdata[irf_pkg::TWO_TIMER_B] && !request_flags_two[irf_pkg::TWO_TIMER_B]
        && !events_in.timer_b_wrap |=> !request_flags_two[irf_pkg::TWO_TIMER_B])
        else $error("write of 1 set a flag");
    clear_zero_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_one && !bus_in.wdata[irf_pkg::ONE_TIMER_A] && !events_in.timer_a_wrap
        |=> !request_flags_one[irf_pkg::ONE_TIMER_A])
        else $error("write of 0 did not clear");
    set_wins_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_two && !bus_in.wdata[irf_pkg::TWO_TIMER_C] && events_in.timer_c_wrap
        |=> request_flags_two[irf_pkg::TWO_TIMER_C])
        else $error("set lost against clear");
    flag_holds_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        request_flags_two[irf_pkg::TWO_TIMER_G] && !wr_two
        |=> request_flags_two[irf_pkg::TWO_TIMER_G])
        else $error("flag dropped without write");
    ext_edge_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        pin_mode[0] && !edge_select_register[0] && $fell(external_request_pins_in[0])
        |=> request_flags_one[0])
        else $error("external edge not flagged");
    wake_fall_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wakeup_mode_in[0] && $fell(wakeup_pins_in[0]) |=> wakeup_request_flags[0])
        else $error("wakeup edge not flagged");
    fl_mode_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !request_flags_two[irf_pkg::TWO_TIMER_FL] && events_in.timer_f_16bit_mode
        |=> !request_flags_two[irf_pkg::TWO_TIMER_FL])
        else $error("fl flag set in 16-bit mode");
    enable_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !enable_flags_two[irf_pkg::TWO_TIMER_B] |-> !pending_two_out[irf_pkg::TWO_TIMER_B])
        else $error("request passed while disabled");

    timer_a_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        events_in.timer_a_wrap |=> request_flags_one[irf_pkg::ONE_TIMER_A])
        else $error("timer a wrap not flagged");

    serial_one_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        events_in.serial_one_done |=> request_flags_one[irf_pkg::ONE_SERIAL_ONE])
        else $error("serial one end not flagged");

    direct_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        events_in.direct_transfer && events_in.direct_transfer_on
        |=> request_flags_two[irf_pkg::TWO_DIRECT])
        else $error("direct transfer not flagged");

    direct_block_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !request_flags_two[irf_pkg::TWO_DIRECT] && !events_in.direct_transfer_on
        |=> !request_flags_two[irf_pkg::TWO_DIRECT])
        else $error("direct flag set while off");

    conversion_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        events_in.conversion_done && !events_in.conversion_start_flag
        |=> request_flags_two[irf_pkg::TWO_CONVERSION])
        else $error("conversion end not flagged");

    conversion_block_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !request_flags_two[irf_pkg::TWO_CONVERSION] && events_in.conversion_start_flag
        |=> !request_flags_two[irf_pkg::TWO_CONVERSION])
        else $error("conversion flag set while busy");

    serial_two_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        events_in.serial_two_end |=> request_flags_two[irf_pkg::TWO_SERIAL_TWO])
        else $error("serial two end not flagged");

    timer_g_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        pin_mode[irf_pkg::MODE_TIMER_G] && (events_in.timer_g_edge || timer_g_capture_pin_hit)
        |=> request_flags_two[irf_pkg::TWO_TIMER_G])
        else $error("timer g capture not flagged");

    timer_fh_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        events_in.timer_f_high_match |=> request_flags_two[irf_pkg::TWO_TIMER_FH])
        else $error("timer fh match not flagged");

    timer_c_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        events_in.timer_c_wrap |=> request_flags_two[irf_pkg::TWO_TIMER_C])
        else $error("timer c wrap not flagged");

    timer_b_set_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        events_in.timer_b_wrap |=> request_flags_two[irf_pkg::TWO_TIMER_B])
        else $error("timer b wrap not flagged");

    ext_rise_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        pin_mode[1] && edge_select_register[1] && $rose(external_request_pins_in[1])
        |=> request_flags_one[1])
        else $error("external rising edge not flagged");
endmodule

// ==== include/irf_pkg.sv ====
// package for the interrupt request flag block: register map, field positions, carriers
package irf_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_FLAGS_ONE = 4'h0;
    localparam logic [3:0] OFF_FLAGS_TWO = 4'h1;
    localparam logic [3:0] OFF_WAKE_FLAGS = 4'h2;
    localparam logic [3:0] OFF_ENABLE_ONE = 4'h3;
    localparam logic [3:0] OFF_ENABLE_TWO = 4'h4;
    localparam logic [3:0] OFF_EDGE_SEL = 4'h5;
    localparam logic [3:0] OFF_PIN_MODE = 4'h6;
    localparam logic [3:0] OFF_REQ_STATUS = 4'h7;
    // request_flags_one fields
    localparam int ONE_TIMER_A = 7;
    localparam int ONE_SERIAL_ONE = 6;
    localparam int ONE_RESERVED = 5;
    localparam int ONE_EXT_MSB = 4;
    localparam int NUM_EXT = 5;
    localparam int NUM_WAKE = 8;
    // request_flags_two fields
    localparam int TWO_DIRECT = 7;
    localparam int TWO_CONVERSION = 6;
    localparam int TWO_SERIAL_TWO = 5;
    localparam int TWO_TIMER_G = 4;
    localparam int TWO_TIMER_FH = 3;
    localparam int TWO_TIMER_FL = 2;
    localparam int TWO_TIMER_C = 1;
    localparam int TWO_TIMER_B = 0;
    // enable_flags_one bit that gates all wakeup flags
    localparam int EN_ONE_WAKE = 5;
    // pin mode register: bits 4..0 external pins, bit 5 timer g capture pin
    localparam int MODE_TIMER_G = 5;
    localparam logic [7:0] RST_FLAGS_ONE = 8'h20;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RESERVED_MASK = 8'h20;

    // hardware event pulses from the peripherals
    typedef struct packed {
        logic timer_a_wrap;
        logic serial_one_done;
        logic direct_transfer;
        logic direct_transfer_on;
        logic conversion_done;
        logic conversion_start_flag;
        logic serial_two_end;
        logic timer_g_edge;
        logic timer_f_high_match;
        logic timer_f_low_match;
        logic timer_f_16bit_mode;
        logic timer_c_wrap;
        logic timer_b_wrap;
    } irf_events_t;

    // software register port
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } irf_bus_t;
endpackage

// ==== dv/irf_far_side.sv ====
// far-side model: three 8-bit timer counters that pulse on wrap, other events passed through
`timescale 1ns/100ps
module irf_far_side (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic load_in,
    input wire logic [7:0] preset_in,
    input wire logic [2:0] run_in,
    input wire irf_pkg::irf_events_t other_in,
    output irf_pkg::irf_events_t events_out
);
    logic [7:0] cnt [3];
    logic [2:0] wrap;
    always_ff @(posedge sys_clk_in) begin
        for (int i = 0; i < 3; i++) begin
            if (rst_in || load_in) begin
                cnt[i] <= rst_in ? 8'h00 : preset_in;
                wrap[i] <= 1'b0;
            end else begin
                cnt[i] <= cnt[i] + {7'h00, run_in[i]};
                wrap[i] <= run_in[i] && (cnt[i] == 8'hff);
            end
        end
    end
    // wrap pulses replace the bench-driven timer events: 2 timer a, 1 timer c, 0 timer b
    always_comb begin
        events_out = other_in;
        events_out.timer_a_wrap = wrap[2];
        events_out.timer_c_wrap = wrap[1];
        events_out.timer_b_wrap = wrap[0];
    end
endmodule

// ==== dv/tb_irf_request_flags.sv ====
// self-checking testbench for the interrupt request flag block
`timescale 1ns/100ps
module tb_irf_request_flags;
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    irf_pkg::irf_bus_t bus = '0;
    irf_pkg::irf_events_t ev = '0;
    irf_pkg::irf_events_t events;
    logic load = 1'b0;
    logic [7:0] preset = 8'h00;
    logic [2:0] run = 3'h0;
    logic [4:0] ext_pins = 5'h1f;
    logic [7:0] wake_pins = 8'hff;
    logic [7:0] wake_mode = 8'h00;
    logic tg_pin = 1'b1;
    logic tg_rise = 1'b0;
    logic [7:0] rdata, one, two, wake, pend_one, pend_two;
    logic any_req;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;
    logic [12:0] ev_tab [10] = '{13'h0800, 13'h0600, 13'h0400, 13'h0100, 13'h0180,
                                 13'h0040, 13'h0010, 13'h0008, 13'h000c, 13'h0020};
    logic [7:0] one_tab [10] = '{8'h60, 8'h20, 8'h20, 8'h20, 8'h20,
                                 8'h20, 8'h20, 8'h20, 8'h20, 8'h20};
    logic [7:0] two_tab [10] = '{8'h00, 8'h80, 8'h00, 8'h40, 8'h00,
                                 8'h20, 8'h08, 8'h04, 8'h00, 8'h00};
    logic [7:0] rst_tab [10] = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
                                 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #50 sys_clk_in = ~sys_clk_in;

    irf_far_side u_irf_far_side (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .load_in(load),
        .preset_in(preset), .run_in(run), .other_in(ev), .events_out(events));

    irf_request_flags u_irf_request_flags (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .bus_in(bus), .rdata_out(rdata), .events_in(events),
        .external_request_pins_in(ext_pins), .wakeup_pins_in(wake_pins),
        .wakeup_mode_in(wake_mode), .timer_g_capture_pin_in(tg_pin), .timer_g_rising_in(tg_rise),
        .request_flags_one_out(one), .request_flags_two_out(two),
        .wakeup_request_flags_out(wake), .pending_one_out(pend_one),
        .pending_two_out(pend_two), .any_request_out(any_req));

    task automatic print_verdict();
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles > 3000) begin
            n_errors = n_errors + 1;
            print_verdict();
        end
    end

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks = checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        bus.rd <= 1'b0;
        #1;
        chk8("read data", exp, rdata);
    endtask

    task automatic flags(input logic [7:0] e1, input logic [7:0] e2);
        chk8("flags one", e1, one);
        chk8("flags two", e2, two);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 9; i++) rd(4'(i), rst_tab[i]);
        rd(4'hf, 8'h00);
        wr(irf_pkg::OFF_FLAGS_ONE, 8'h00);
        rd(irf_pkg::OFF_FLAGS_ONE, irf_pkg::RST_FLAGS_ONE);
        // timer counters wrap from ff to 00 after three increments
        @(posedge sys_clk_in);
        load <= 1'b1;
        preset <= 8'hfd;
        @(posedge sys_clk_in);
        load <= 1'b0;
        run <= 3'h7;
        repeat (2) @(posedge sys_clk_in);
        #1;
        flags(8'h20, 8'h00);
        repeat (4) @(posedge sys_clk_in);
        run <= 3'h0;
        #1;
        flags(8'ha0, 8'h03);
        wr(irf_pkg::OFF_FLAGS_ONE, 8'hff);
        flags(8'ha0, 8'h03);
        rd(irf_pkg::OFF_FLAGS_TWO, 8'h03);
        wr(irf_pkg::OFF_FLAGS_ONE, 8'h7f);
        wr(irf_pkg::OFF_FLAGS_TWO, 8'hfc);
        flags(8'h20, 8'h00);
        wr(irf_pkg::OFF_FLAGS_TWO, 8'hff);
        flags(8'h20, 8'h00);
        // single event pulses, with conditions that must block some of them
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk_in);
            ev <= ev_tab[i];
            @(posedge sys_clk_in);
            ev <= '0;
            #1;
            flags(one_tab[i], two_tab[i]);
            wr(irf_pkg::OFF_FLAGS_ONE, 8'h00);
            wr(irf_pkg::OFF_FLAGS_TWO, 8'h00);
        end
        wr(irf_pkg::OFF_PIN_MODE, 8'h20);
        @(posedge sys_clk_in);
        ev <= 13'h0020;
        // hardware set lands in the same cycle as a software clear
        bus <= '{addr: irf_pkg::OFF_FLAGS_TWO, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        ev <= '0;
        bus.wr <= 1'b0;
        #1;
        flags(8'h20, 8'h10);
        wr(irf_pkg::OFF_FLAGS_TWO, 8'h00);
        // capture pin edges, falling then rising polarity
        @(posedge sys_clk_in);
        tg_pin <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        #1;
        flags(8'h20, 8'h10);
        wr(irf_pkg::OFF_FLAGS_TWO, 8'h00);
        @(posedge sys_clk_in);
        tg_rise <= 1'b1;
        tg_pin <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        #1;
        flags(8'h20, 8'h10);
        wr(irf_pkg::OFF_FLAGS_TWO, 8'h00);
        // external pins: pin 1 rising selected, pin 0 falling, pin 4 not in interrupt mode
        wr(irf_pkg::OFF_EDGE_SEL, 8'h02);
        wr(irf_pkg::OFF_PIN_MODE, 8'h03);
        @(posedge sys_clk_in);
        ext_pins <= 5'h1c;
        repeat (2) @(posedge sys_clk_in);
        #1;
        flags(8'h21, 8'h00);
        @(posedge sys_clk_in);
        ext_pins <= 5'h0e;
        repeat (2) @(posedge sys_clk_in);
        #1;
        flags(8'h23, 8'h00);
        wr(irf_pkg::OFF_PIN_MODE, 8'h13);
        repeat (2) @(posedge sys_clk_in);
        wr(irf_pkg::OFF_FLAGS_ONE, 8'hef);
        flags(8'h23, 8'h00);
        // timer wraps land in the same cycle as a software clear of flags two
        @(posedge sys_clk_in);
        load <= 1'b1;
        preset <= 8'hfe;
        @(posedge sys_clk_in);
        load <= 1'b0;
        run <= 3'h7;
        repeat (2) @(posedge sys_clk_in);
        bus <= '{addr: irf_pkg::OFF_FLAGS_TWO, wdata: 8'h00, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        bus.wr <= 1'b0;
        run <= 3'h0;
        #1;
        flags(8'ha3, 8'h03);
        wr(irf_pkg::OFF_FLAGS_ONE, 8'h7f);
        wr(irf_pkg::OFF_FLAGS_TWO, 8'h00);
        flags(8'h23, 8'h00);
        // wakeup pins, only the low four in wakeup mode
        @(posedge sys_clk_in);
        wake_mode <= 8'h0f;
        @(posedge sys_clk_in);
        wake_pins <= 8'h00;
        repeat (2) @(posedge sys_clk_in);
        #1;
        chk8("wakeup flags", 8'h0f, wake);
        chk8("pending one", 8'h00, pend_one);
        wr(irf_pkg::OFF_ENABLE_ONE, 8'h20);
        chk8("pending one", 8'h20, pend_one);
        chk8("any request", 8'h01, {7'h00, any_req});
        rd(irf_pkg::OFF_REQ_STATUS, 8'h01);
        rd(irf_pkg::OFF_WAKE_FLAGS, 8'h0f);
        wr(irf_pkg::OFF_WAKE_FLAGS, 8'hf0);
        chk8("any request", 8'h00, {7'h00, any_req});
        print_verdict();
    end
endmodule
